// *** hdl/vpc_defines.vh ***
// Purpose: constants for the legacy plane control bank
// Assumes: byte addresses on a 20-bit register port
// Notes: definitions only
`ifndef VPC_DEFINES_VH
`define VPC_DEFINES_VH

// register byte offsets
`define VPC_OFS_SCRATCH0 20'h70410
`define VPC_OFS_SCRATCH1 20'h70414
`define VPC_OFS_SCRATCH2 20'h70418
`define VPC_OFS_SCRATCH3 20'h7041c
`define VPC_OFS_SCRATCH4 20'h70420
`define VPC_OFS_CONTROL 20'h71400

// reset values
`define VPC_RST_SCRATCH 32'h00000000
`define VPC_RST_CONTROL 32'h00000000

// control word field positions
`define VPC_BIT_DISP_OFF 31
`define VPC_BIT_DOUBLE 30
`define VPC_BIT_PIPE_SEL 29
`define VPC_BIT_RSVD_HI 28
`define VPC_BIT_RSVD_LO 27
`define VPC_BIT_BORDER 26
`define VPC_BIT_CENTER_HI 25
`define VPC_BIT_CENTER_LO 24
`define VPC_BIT_PAL_RD_B 23
`define VPC_BIT_PAL_WR_OFF_A 22
`define VPC_BIT_PAL_WR_OFF_B 21
`define VPC_BIT_PAL_8BIT 20
`define VPC_BIT_NINE_DOT_OFF 18
`define VPC_BIT_DUTY_HI 7
`define VPC_BIT_DUTY_LO 6
`define VPC_BIT_RATE_HI 5
`define VPC_BIT_RATE_LO 0

// centering field codes
`define VPC_CTR_NATIVE 2'h0
`define VPC_CTR_MIDDLE 2'h1
`define VPC_CTR_UPLEFT 2'h2

// blink duty codes
`define VPC_DUTY_FULL 2'h0

// palette shift in 6-bit mode
`define VPC_PAL_SHIFT 2

`endif

// *** hdl/vpc_scratch_reg.v ***
// Purpose: one software scratch word
// Assumes: single clock, asynchronous active-low reset
// Notes: value has no effect on hardware
`timescale 1ns/10ps
module vpc_scratch_reg #(
  parameter [31:0] RESET_VALUE = 32'h00000000
) (
  clk,
  rst_n,
  wrEn,
  wrData,
  value
);
  input wire clk;
  input wire rst_n;
  input wire wrEn;
  input wire [31:0] wrData;
  output wire [31:0] value;

  reg [31:0] word_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_ff <= RESET_VALUE;
    end else if (wrEn) begin
      word_ff <= wrData;
    end
  end

  assign value = word_ff;
endmodule // vpc_scratch_reg

// *** hdl/vpc_plane_control_bank.v ***
// Purpose: legacy plane control word and software scratch words
// Assumes: one 25 MHz clock; palette, fitter and legacy inputs on it
// Notes: register reads answer one cycle after the read strobe
`timescale 1ns/10ps
`include "vpc_defines.vh"
module vpc_plane_control_bank #(
  parameter DUAL_PIPE = 1
) (
  clk,
  rst_n,
  regAddr,
  regWrData,
  regWr,
  regRd,
  regRdData,
  pfitOnPipeA,
  pfitOnPipeB,
  ioPalWr,
  ioPalWrData,
  ioPalRd,
  palDataA,
  palDataB,
  legacyDotWidthBit,
  vsyncPulse,
  fetchReq,
  fetchAddr,
  regionBase,
  regionTop,
  displayOn,
  pipeSelB,
  pixelDouble,
  borderEnable,
  placeMode,
  timingFromLegacy,
  palWrEnA,
  palWrEnB,
  palWrData,
  palRdSelB,
  ioPalRdData,
  nineDot,
  panEmulateNine,
  cursorBlinkOn,
  textBlinkOn,
  fetchGrant,
  fetchBlocked
);
  input wire clk;
  input wire rst_n;
  input wire [19:0] regAddr;
  input wire [31:0] regWrData;
  input wire regWr;
  input wire regRd;
  output reg [31:0] regRdData;
  input wire pfitOnPipeA;
  input wire pfitOnPipeB;
  input wire ioPalWr;
  input wire [7:0] ioPalWrData;
  input wire ioPalRd;
  input wire [7:0] palDataA;
  input wire [7:0] palDataB;
  input wire legacyDotWidthBit;
  input wire vsyncPulse;
  input wire fetchReq;
  input wire [31:0] fetchAddr;
  input wire [31:0] regionBase;
  input wire [31:0] regionTop;
  output reg displayOn;
  output reg pipeSelB;
  output reg pixelDouble;
  output reg borderEnable;
  output reg [1:0] placeMode;
  output reg timingFromLegacy;
  output reg palWrEnA;
  output reg palWrEnB;
  output reg [7:0] palWrData;
  output reg palRdSelB;
  output reg [7:0] ioPalRdData;
  output reg nineDot;
  output reg panEmulateNine;
  output reg cursorBlinkOn;
  output reg textBlinkOn;
  output reg fetchGrant;
  output reg fetchBlocked;

  // ---------------- register file ----------------
  reg [31:0] ctrl_ff;
  wire [31:0] scratch0;
  wire [31:0] scratch1;
  wire [31:0] scratch2;
  wire [31:0] scratch3;
  wire [31:0] scratch4;

  wire hitCtrl = (regAddr == `VPC_OFS_CONTROL);
  wire hitS0 = (regAddr == `VPC_OFS_SCRATCH0);
  wire hitS1 = (regAddr == `VPC_OFS_SCRATCH1);
  wire hitS2 = (regAddr == `VPC_OFS_SCRATCH2);
  wire hitS3 = (regAddr == `VPC_OFS_SCRATCH3);
  wire hitS4 = (regAddr == `VPC_OFS_SCRATCH4);

  // every bit, reserved ones too, is stored so software can preserve them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `VPC_RST_CONTROL;
    end else if (regWr && hitCtrl) begin
      ctrl_ff <= regWrData;
    end
  end

  vpc_scratch_reg #(.RESET_VALUE(`VPC_RST_SCRATCH)) u_scratch0 (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(regWr && hitS0),
    .wrData(regWrData),
    .value(scratch0)
  );
  vpc_scratch_reg #(.RESET_VALUE(`VPC_RST_SCRATCH)) u_scratch1 (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(regWr && hitS1),
    .wrData(regWrData),
    .value(scratch1)
  );
  vpc_scratch_reg #(.RESET_VALUE(`VPC_RST_SCRATCH)) u_scratch2 (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(regWr && hitS2),
    .wrData(regWrData),
    .value(scratch2)
  );
  vpc_scratch_reg #(.RESET_VALUE(`VPC_RST_SCRATCH)) u_scratch3 (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(regWr && hitS3),
    .wrData(regWrData),
    .value(scratch3)
  );
  vpc_scratch_reg #(.RESET_VALUE(`VPC_RST_SCRATCH)) u_scratch4 (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(regWr && hitS4),
    .wrData(regWrData),
    .value(scratch4)
  );

  // read data valid only in the cycle after the strobe; unmapped reads zero
  // misaligned addresses match no word, so they read zero as well
  reg [31:0] nxt_rdData;
  always @* begin
    nxt_rdData = 32'h00000000;
    if (regRd) begin
      case (regAddr)
        `VPC_OFS_CONTROL: begin
          nxt_rdData = ctrl_ff;
        end
        `VPC_OFS_SCRATCH0: begin
          nxt_rdData = scratch0;
        end
        `VPC_OFS_SCRATCH1: begin
          nxt_rdData = scratch1;
        end
        `VPC_OFS_SCRATCH2: begin
          nxt_rdData = scratch2;
        end
        `VPC_OFS_SCRATCH3: begin
          nxt_rdData = scratch3;
        end
        `VPC_OFS_SCRATCH4: begin
          nxt_rdData = scratch4;
        end
        default: begin
          nxt_rdData = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 32'h00000000;
    end else begin
      regRdData <= nxt_rdData;
    end
  end

  // ---------------- control field decode ----------------
  // derived outputs lag the stored control word by one cycle
  wire fDispOff = ctrl_ff[`VPC_BIT_DISP_OFF];
  wire fDouble = ctrl_ff[`VPC_BIT_DOUBLE];
  wire fPipeB = ctrl_ff[`VPC_BIT_PIPE_SEL];
  wire fBorder = ctrl_ff[`VPC_BIT_BORDER];
  wire [1:0] fCenter = ctrl_ff[`VPC_BIT_CENTER_HI:`VPC_BIT_CENTER_LO];
  wire fPalRdB = ctrl_ff[`VPC_BIT_PAL_RD_B];
  wire fPalWrOffA = ctrl_ff[`VPC_BIT_PAL_WR_OFF_A];
  wire fPalWrOffB = ctrl_ff[`VPC_BIT_PAL_WR_OFF_B];
  wire fPal8 = ctrl_ff[`VPC_BIT_PAL_8BIT];
  wire fNineOff = ctrl_ff[`VPC_BIT_NINE_DOT_OFF];
  wire [1:0] fDuty = ctrl_ff[`VPC_BIT_DUTY_HI:`VPC_BIT_DUTY_LO];
  wire [5:0] fRate = ctrl_ff[`VPC_BIT_RATE_HI:`VPC_BIT_RATE_LO];

  // single-pipe builds always use pipe A
  wire effPipeB = (DUAL_PIPE != 0) ? fPipeB : 1'b0;
  wire effPalRdB = (DUAL_PIPE != 0) ? fPalRdB : 1'b0;
  wire fitOnVgaPipe = effPipeB ? pfitOnPipeB : pfitOnPipeA;

  reg [1:0] nxt_place;
  always @* begin
    case (fCenter)
      `VPC_CTR_NATIVE: nxt_place = `VPC_CTR_NATIVE;
      `VPC_CTR_MIDDLE: nxt_place = `VPC_CTR_MIDDLE;
      default: nxt_place = `VPC_CTR_UPLEFT;
    endcase
    if (fitOnVgaPipe) begin
      nxt_place = `VPC_CTR_UPLEFT;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      displayOn <= 1'b0;
      pipeSelB <= 1'b0;
      pixelDouble <= 1'b0;
      borderEnable <= 1'b0;
      placeMode <= `VPC_CTR_NATIVE;
      timingFromLegacy <= 1'b0;
      nineDot <= 1'b0;
      panEmulateNine <= 1'b0;
    end else begin
      displayOn <= ~fDispOff;
      pipeSelB <= effPipeB;
      pixelDouble <= fDouble;
      borderEnable <= fBorder;
      placeMode <= nxt_place;
      timingFromLegacy <= (nxt_place == `VPC_CTR_NATIVE);
      nineDot <= legacyDotWidthBit & ~fNineOff;
      panEmulateNine <= fNineOff & ~legacyDotWidthBit;
    end
  end

  // ---------------- legacy palette port ----------------
  // write enables are one-cycle pulses; captured data holds until next access
  wire [7:0] rdSel = effPalRdB ? palDataB : palDataA;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      palWrEnA <= 1'b0;
      palWrEnB <= 1'b0;
      palWrData <= 8'h00;
      palRdSelB <= 1'b0;
      ioPalRdData <= 8'h00;
    end else begin
      palWrEnA <= ioPalWr & ~fPalWrOffA;
      palWrEnB <= ioPalWr & ~fPalWrOffB & (DUAL_PIPE != 0);
      palRdSelB <= effPalRdB;
      if (ioPalWr) begin
        palWrData <= fPal8 ? ioPalWrData : (ioPalWrData << `VPC_PAL_SHIFT);
      end
      if (ioPalRd) begin
        ioPalRdData <= fPal8 ? rdSel : (rdSel >> `VPC_PAL_SHIFT);
      end
    end
  end

  // ---------------- blink generation ----------------
  // one quarter of the text cycle is rate+1 vsyncs; cursor toggles each quarter
  reg [5:0] vsCount_ff;
  reg [1:0] quarter_ff;
  wire quarterEnd = vsyncPulse && (vsCount_ff >= fRate);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vsCount_ff <= 6'h00;
      quarter_ff <= 2'h0;
    end else if (vsyncPulse) begin
      if (quarterEnd) begin
        vsCount_ff <= 6'h00;
        quarter_ff <= quarter_ff + 2'h1;
      end else begin
        vsCount_ff <= vsCount_ff + 6'h01;
      end
    end
  end

  // cursor: on during even quarters, so its period is 2*(rate+1) vsyncs
  wire cursorPhase = ~quarter_ff[0];
  reg nxt_text;
  always @* begin
    case (fDuty)
      `VPC_DUTY_FULL: begin
        nxt_text = cursorPhase;
      end
      default: begin
        nxt_text = (quarter_ff < fDuty);
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cursorBlinkOn <= 1'b0;
      textBlinkOn <= 1'b0;
    end else begin
      cursorBlinkOn <= cursorPhase;
      textBlinkOn <= nxt_text;
    end
  end

  // ---------------- fetch confinement ----------------
  // fetches outside [base, top) are refused; no 132-column mode exists
  // a grant also needs the display on, a refusal does not
  wire inRegion = (fetchAddr >= regionBase) && (fetchAddr < regionTop);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetchGrant <= 1'b0;
      fetchBlocked <= 1'b0;
    end else begin
      fetchGrant <= fetchReq & inRegion & ~fDispOff;
      fetchBlocked <= fetchReq & ~inRegion;
    end
  end
endmodule // vpc_plane_control_bank

// *** verification/vpc_plane_control_bank_assertions.sv ***
// Purpose: port assertions for the legacy plane control bank
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every instance of the bank
`timescale 1ns/10ps
module vpc_bank_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic ioPalWr,
  input wire logic palWrEnA,
  input wire logic palWrEnB,
  input wire logic legacyDotWidthBit,
  input wire logic nineDot,
  input wire logic panEmulateNine,
  input wire logic [1:0] placeMode,
  input wire logic timingFromLegacy,
  input wire logic pfitOnPipeA,
  input wire logic pfitOnPipeB,
  input wire logic fetchReq,
  input wire logic fetchGrant,
  input wire logic fetchBlocked,
  input wire logic displayOn,
  input wire logic vsyncPulse,
  input wire logic cursorBlinkOn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!regRd |=> regRdData == 32'h0)
    else $error("read data not cleared");
  pal_idle_a: assert property (!ioPalWr |=> !palWrEnA && !palWrEnB)
    else $error("palette write without request");
  dot_excl_a: assert property (!(nineDot && panEmulateNine))
    else $error("nine dot and emulation together");
  dot_src_a: assert property (nineDot |-> $past(legacyDotWidthBit))
    else $error("nine dot without legacy bit");
  place_code_a: assert property (placeMode != 2'h3)
    else $error("placement code three driven");
  legacy_timing_a: assert property (rst_n && $past(rst_n) |-> timingFromLegacy == (placeMode == 2'h0))
    else $error("timing source disagrees with placement");
  fitter_force_a: assert property (pfitOnPipeA && pfitOnPipeB |=> placeMode == 2'h2)
    else $error("fitter did not force upper left");
  grant_on_a: assert property (fetchGrant |-> displayOn && !fetchBlocked && $past(fetchReq))
    else $error("fetch grant without cause");
  blink_hold_a: assert property (rst_n && !vsyncPulse ##1 !vsyncPulse |=> $stable(cursorBlinkOn))
    else $error("cursor blink moved without vsync");
endmodule // vpc_bank_checker

bind vpc_plane_control_bank vpc_bank_checker u_chk (.*);

// *** verification/vpc_plane_control_bank_test.sv ***
// Purpose: self-checking bench for the legacy plane control bank
// Assumes: 25 MHz clock, bench drives on the rising edge
// Notes: expectations come from the control word layout
`timescale 1ns/10ps
`include "vpc_defines.vh"
module vpc_plane_control_bank_test;
  logic clk, rst_n, regWr, regRd, pfitOnPipeA, pfitOnPipeB, ioPalWr, ioPalRd;
  logic legacyDotWidthBit, vsyncPulse, fetchReq, prev;
  logic [19:0] regAddr;
  logic [31:0] regWrData, fetchAddr, regionBase, regionTop;
  logic [7:0] ioPalWrData, palDataA, palDataB, e;
  wire [31:0] regRdData;
  wire [7:0] palWrData, ioPalRdData;
  wire [1:0] placeMode;
  wire displayOn, pipeSelB, pixelDouble, borderEnable, timingFromLegacy, palWrEnA, palWrEnB;
  wire palRdSelB, nineDot, panEmulateNine, cursorBlinkOn, textBlinkOn, fetchGrant, fetchBlocked;
  int fails = 0, comparisons = 0, i, j, n, m;
  localparam logic [19:0] C = `VPC_OFS_CONTROL;
  localparam logic [19:0] S0 = `VPC_OFS_SCRATCH0;
  vpc_plane_control_bank DUT (.*);
  task automatic ck(input string s, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      fails++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [31:0] x);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    ck("regRdData", x, regRdData);
  endtask
  task automatic st;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic ctl(input logic [31:0] d);
    wr(C, d);
    st;
  endtask
  task automatic pal(input logic w, input logic r);
    @(posedge clk);
    ioPalWr <= w;
    ioPalRd <= r;
    @(posedge clk);
    ioPalWr <= 1'b0;
    ioPalRd <= 1'b0;
    #1;
  endtask
  task automatic vs;
    @(posedge clk);
    vsyncPulse <= 1'b1;
    @(posedge clk);
    vsyncPulse <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #500000;
    fails++;
    complete_run;
  end
  initial begin
    {rst_n, regWr, regRd, pfitOnPipeA, pfitOnPipeB, ioPalWr, ioPalRd} = 7'h0;
    {legacyDotWidthBit, vsyncPulse, fetchReq, regAddr, regWrData, fetchAddr, ioPalWrData} = '0;
    regionBase = 32'h1000;
    regionTop = 32'h2000;
    palDataA = 8'hc4;
    palDataB = 8'h81;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    st;
    for (i = 0; i < 5; i++) rd(S0 + 20'(i * 4), 32'h0);
    rd(C, `VPC_RST_CONTROL);
    ck("displayOn legacy", 2'b11, {displayOn, timingFromLegacy});
    $display("reset test done");
    for (i = 0; i < 5; i++) wr(S0 + 20'(i * 4), {28'ha5c3e71, 4'(i)});
    wr(S0 + 20'h1, 32'h0);
    wr(20'h70424, 32'hffffffff);
    for (i = 0; i < 5; i++) rd(S0 + 20'(i * 4), {28'ha5c3e71, 4'(i)});
    rd(20'h70424, 32'h0);
    $display("scratch test done");
    ctl(32'h80000000);
    ctl(32'he7ffffff);
    rd(C, 32'he7ffffff);
    ck("flags", 4'b0111, {displayOn, pixelDouble, pipeSelB, borderEnable});
    ctl(32'h0);
    ck("flags", 4'b1000, {displayOn, pixelDouble, pipeSelB, borderEnable});
    for (i = 0; i < 4; i++) begin
      ctl(i << 24);
      ck("placeMode", (i == 0) ? 0 : (i == 1) ? 1 : 2, placeMode);
      ck("timingFromLegacy", i == 0, timingFromLegacy);
    end
    @(posedge clk);
    pfitOnPipeA <= 1'b1;
    pfitOnPipeB <= 1'b1;
    for (j = 0; j < 2; j++) begin
      ctl(32'h81000000 | (j << 29));
      ck("fitted place", 3'b100, {placeMode, timingFromLegacy});
    end
    @(posedge clk);
    pfitOnPipeA <= 1'b0;
    ctl(32'h01000000);
    ck("other pipe place", 3'b010, {placeMode, timingFromLegacy});
    $display("control test done");
    @(posedge clk);
    ioPalWrData <= 8'h3f;
    for (i = 0; i < 4; i++) begin
      ctl(i << 21);
      pal(1'b1, 1'b0);
      ck("palWrEn", {!i[1], !i[0]}, {palWrEnA, palWrEnB});
      ck("palWrData", 8'hfc, palWrData);
    end
    ctl(32'h00100000);
    pal(1'b1, 1'b0);
    ck("palWrData", 8'h3f, palWrData);
    for (i = 0; i < 4; i++) begin
      ctl((32'(i[1]) << 20) | (32'(i[0]) << 23));
      pal(1'b0, 1'b1);
      ck("palRdSelB", i[0], palRdSelB);
      e = i[0] ? 8'h81 : 8'hc4;
      e = i[1] ? e : (e >> 2);
      ck("ioPalRdData", e, ioPalRdData);
    end
    $display("palette test done");
    @(posedge clk);
    legacyDotWidthBit <= 1'b1;
    ctl(32'h0);
    ck("dots", 2'b10, {nineDot, panEmulateNine});
    ctl(32'h00040000);
    ck("dots", 2'b00, {nineDot, panEmulateNine});
    @(posedge clk);
    legacyDotWidthBit <= 1'b0;
    st;
    ck("dots", 2'b01, {nineDot, panEmulateNine});
    $display("dot test done");
    for (i = 0; i < 4; i++) begin
      ctl((i << 6) | 1);
      prev = cursorBlinkOn;
      n = 0;
      m = 0;
      for (j = 0; j < 16; j++) begin
        vs;
        n += (cursorBlinkOn !== prev);
        prev = cursorBlinkOn;
        m += (textBlinkOn === 1'b1);
      end
      ck("cursor toggles", 8, n);
      ck("text on", (i == 0) ? 8 : 4 * i, m);
    end
    $display("blink test done");
    @(posedge clk);
    fetchReq <= 1'b1;
    fetchAddr <= 32'h1ffc;
    ctl(32'h0);
    ck("fetch", 2'b10, {fetchGrant, fetchBlocked});
    @(posedge clk);
    fetchAddr <= 32'h2000;
    st;
    ck("fetch", 2'b01, {fetchGrant, fetchBlocked});
    @(posedge clk);
    fetchAddr <= 32'h1000;
    ctl(32'h80000000);
    ck("fetch", 2'b00, {fetchGrant, fetchBlocked});
    $display("fetch test done");
    complete_run;
  end
endmodule // vpc_plane_control_bank_test
